// ### verilog/time_event_defines.svh
// Purpose: Constants for the two-channel time event comparator.
// Assumes: 100 MHz mclk, 16-bit register quarters.
// Notes: Offsets do not exist here; control bits are plain ports.
// Contract
// - Counter is 48 bits seconds plus 30 bits nanoseconds.
// - Two independent event channels, A and B, each fully equipped.
// - Compare uses only low 32 seconds bits plus nanoseconds.
// - Target changes only after all four quarters written, any order.
// - Readback command copies both current targets to readable registers.
// - Event fires when counter is greater than or equal to target.
// - Event sets the channel interrupt status flag.
// - Event captures counter nanoseconds into actual-nanoseconds register.
// - Select bit one reloads target from rearm registers.
// - Select bit zero adds rearm value; nanoseconds wrap at 10^9.
// - Rearm value takes effect only after all four quarters written.
// - Writing counter at or beyond target may fire event at once.
// - GPIO input clears event flag; GPIO output follows event.
// - GPIO input transition captures counter into capture registers.
// - Counter, targets and GPIO features run only with global enable; the GPIO input still clears the event flag while disabled.
// - Port processing needs port enable and global enable.
// - Disable finishes frames in progress, then clears both bits.
// - Global enable low halts counter, detection, GPIO stamping, events.
// - Global enable low lets frames bypass pipeline undelayed.
// - Registers stay writable and status preserved while disabled.
// - Event pins flag target reached; either may act as pulse output.
`ifndef TIME_EVENT_DEFINES_SVH
`define TIME_EVENT_DEFINES_SVH
`define NS_PER_SEC        30'h3B9ACA00
`define CLK_PERIOD_NS     30'h0000000A
`define PULSE_WIDTH_NS    32'h00000064
`define PULSE_CYCLES      (`PULSE_WIDTH_NS / 32'h0000000A)
`define QUARTER_ALL       4'hF
`define Q_NS_LO           2'h0
`define Q_NS_HI           2'h1
`define Q_SEC_LO          2'h2
`define Q_SEC_HI          2'h3
`define CHAN_A            1'h0
`define CHAN_B            1'h1
`endif

// ### verilog/time_event_pkg.sv
// Purpose: Shared types for the time event comparator.
// Assumes: Included defines header supplies all numbers.
// Notes: Types only.
package time_event_pkg;
    typedef struct packed {
        logic [31:0] sec;
        logic [29:0] ns;
    } tod_t;
    typedef enum logic [1:0] {
        stamp_idle,
        stamp_busy,
        stamp_drain
    } stamp_state_t;
endpackage

// ### verilog/quarter_if.sv
// Purpose: Quarter-write carrier between the top and the staging modules.
// Assumes: One quarter write per cycle.
// Notes: Used for both target and rearm sets.
`timescale 1ns/1ps
interface quarter_if;
    logic                      wr;
    logic [1:0]                sel;
    logic [15:0]               data;
    logic                      commit;
    time_event_pkg::tod_t      value;
    modport src (output wr, output sel, output data, input commit,
                 input value);
    modport dst (input wr, input sel, input data, output commit,
                 output value);
endinterface

// ### verilog/quarter_stage.sv
// Purpose: Collects four 16-bit quarters and commits them as one value.
// Assumes: Quarters may arrive in any order.
// Notes: A rewrite of one quarter before completion just overwrites it.
`timescale 1ns/1ps
`include "time_event_defines.svh"
module quarter_stage (
    input  wire logic mclk,
    input  wire logic sys_rst,
    quarter_if.dst    q
);
    logic [63:0] shadow;
    logic [3:0]  seen;
    logic [3:0]  next_seen;

    always_comb begin
        next_seen = seen;
        if (q.wr) begin
            next_seen[q.sel] = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            shadow <= 64'h0;
        end else if (q.wr) begin
            shadow[q.sel*16 +: 16] <= q.data;
        end
    end

    // The set only takes effect once every quarter has arrived.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            seen     <= 4'h0;
            q.commit <= 1'b0;
        end else if (next_seen == `QUARTER_ALL) begin
            seen     <= 4'h0;
            q.commit <= 1'b1;
        end else begin
            seen     <= next_seen;
            q.commit <= 1'b0;
        end
    end

    assign q.value.ns  = shadow[29:0];
    assign q.value.sec = shadow[63:32];
endmodule

// ### verilog/ptp_time_event_compare.sv
// Purpose: Two-channel time event comparator with global enable control.
// Assumes: Counter writes and quarter writes arrive as one-cycle strobes.
// Notes: Pins must already be set up as GPIO alternate functions.
`timescale 1ns/1ps
`include "time_event_defines.svh"
module ptp_time_event_compare (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        counter_load,
    input  wire logic [47:0] counter_load_sec,
    input  wire logic [29:0] counter_load_ns,
    input  wire logic [1:0]  target_wr,
    input  wire logic [1:0]  rearm_wr,
    input  wire logic [1:0]  quarter_sel,
    input  wire logic [15:0] quarter_data,
    input  wire logic        target_readback_cmd,
    input  wire logic [1:0]  rearm_reload,
    input  wire logic        enable_set,
    input  wire logic        disable_set,
    input  wire logic [3:0]  port_stamp_unit_enable,
    input  wire logic [3:0]  port_frame_busy,
    input  wire logic [1:0]  irq_clear,
    input  wire logic [1:0]  gpio_irq_clear,
    input  wire logic        gpio_capture_in,
    output logic [47:0]      local_time_counter_sec,
    output logic [29:0]      local_time_counter_ns,
    output logic             sync_global_enable,
    output logic             sync_global_disable,
    output logic [3:0]       port_process_enable,
    output logic             stamp_bypass,
    output logic             event_irq_chan_a,
    output logic             event_irq_chan_b,
    output logic [31:0]      event_target_seconds_a,
    output logic [29:0]      event_target_nanoseconds_a,
    output logic [31:0]      event_target_seconds_b,
    output logic [29:0]      event_target_nanoseconds_b,
    output logic [29:0]      actual_ns_a,
    output logic [29:0]      actual_ns_b,
    output logic [47:0]      capture_sec,
    output logic [29:0]      capture_ns,
    output logic [1:0]       event_pin,
    output logic [1:0]       gpio_event_out
);
    quarter_if tq [2] ();
    quarter_if rq [2] ();

    time_event_pkg::tod_t target [2];
    time_event_pkg::tod_t rearm  [2];
    logic [1:0]           hit;
    logic [1:0]           irq_flag;
    logic [3:0]           pulse_cnt [2];
    logic                 capture_prev;
    time_event_pkg::stamp_state_t state;

    // Nanosecond-wrapping add of a rearm period onto a target.
    function automatic time_event_pkg::tod_t tod_add(
        input time_event_pkg::tod_t a,
        input time_event_pkg::tod_t b
    );
        logic [30:0] sum;
        sum = {1'b0, a.ns} + {1'b0, b.ns};
        if (sum >= {1'b0, `NS_PER_SEC}) begin
            tod_add.ns  = 30'(sum - {1'b0, `NS_PER_SEC});
            tod_add.sec = a.sec + b.sec + 32'h1;
        end else begin
            tod_add.ns  = sum[29:0];
            tod_add.sec = a.sec + b.sec;
        end
    endfunction

    // Greater-or-equal on the low 32 seconds bits and nanoseconds.
    function automatic logic tod_ge(
        input logic [31:0]          sec,
        input logic [29:0]          ns,
        input time_event_pkg::tod_t t
    );
        tod_ge = ({sec, ns} >= {t.sec, t.ns});
    endfunction

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            assign tq[ch].wr   = target_wr[ch];
            assign tq[ch].sel  = quarter_sel;
            assign tq[ch].data = quarter_data;
            assign rq[ch].wr   = rearm_wr[ch];
            assign rq[ch].sel  = quarter_sel;
            assign rq[ch].data = quarter_data;

            quarter_stage u_tstage (
                .mclk    (mclk),
                .sys_rst (sys_rst),
                .q       (tq[ch])
            );
            quarter_stage u_rstage (
                .mclk    (mclk),
                .sys_rst (sys_rst),
                .q       (rq[ch])
            );

            // Includes the case where a counter load lands past the target.
            assign hit[ch] = sync_global_enable
                && tod_ge(local_time_counter_sec[31:0],
                          local_time_counter_ns, target[ch]);

            // A fresh software target wins over the automatic rearm.
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    target[ch] <= '0;
                end else if (tq[ch].commit) begin
                    target[ch] <= tq[ch].value;
                end else if (hit[ch] && rearm_reload[ch]) begin
                    target[ch] <= rearm[ch];
                end else if (hit[ch]) begin
                    target[ch] <= tod_add(target[ch], rearm[ch]);
                end
            end

            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    rearm[ch] <= '0;
                end else if (rq[ch].commit) begin
                    rearm[ch] <= rq[ch].value;
                end
            end

            // Set wins over a clear in the same cycle.
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    irq_flag[ch] <= 1'b0;
                end else if (hit[ch]) begin
                    irq_flag[ch] <= 1'b1;
                end else if (irq_clear[ch] || gpio_irq_clear[ch]) begin
                    irq_flag[ch] <= 1'b0;
                end
            end

            // The pin pulse has a fixed width so it can serve as a PPS.
            always_ff @(posedge mclk) begin
                if (sys_rst) begin
                    pulse_cnt[ch]      <= 4'h0;
                    event_pin[ch]      <= 1'b0;
                    gpio_event_out[ch] <= 1'b0;
                end else if (hit[ch]) begin
                    pulse_cnt[ch]      <= 4'(`PULSE_CYCLES - 32'h1);
                    event_pin[ch]      <= 1'b1;
                    gpio_event_out[ch] <= 1'b1;
                end else if (pulse_cnt[ch] != 4'h0) begin
                    pulse_cnt[ch]      <= pulse_cnt[ch] - 4'h1;
                end else begin
                    event_pin[ch]      <= 1'b0;
                    gpio_event_out[ch] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            event_irq_chan_a <= 1'b0;
            event_irq_chan_b <= 1'b0;
        end else begin
            event_irq_chan_a <= irq_flag[`CHAN_A];
            event_irq_chan_b <= irq_flag[`CHAN_B];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            actual_ns_a <= 30'h0;
            actual_ns_b <= 30'h0;
        end else begin
            if (hit[`CHAN_A]) begin
                actual_ns_a <= local_time_counter_ns;
            end
            if (hit[`CHAN_B]) begin
                actual_ns_b <= local_time_counter_ns;
            end
        end
    end

    // Readback is only a snapshot; it does not follow later rearms.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            event_target_seconds_a     <= 32'h0;
            event_target_nanoseconds_a <= 30'h0;
            event_target_seconds_b     <= 32'h0;
            event_target_nanoseconds_b <= 30'h0;
        end else if (target_readback_cmd) begin
            event_target_seconds_a     <= target[`CHAN_A].sec;
            event_target_nanoseconds_a <= target[`CHAN_A].ns;
            event_target_seconds_b     <= target[`CHAN_B].sec;
            event_target_nanoseconds_b <= target[`CHAN_B].ns;
        end
    end

    // Loads are accepted while disabled; only the ticking halts.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            local_time_counter_sec <= 48'h0;
            local_time_counter_ns  <= 30'h0;
        end else if (counter_load) begin
            local_time_counter_sec <= counter_load_sec;
            local_time_counter_ns  <= counter_load_ns;
        end else if (sync_global_enable) begin
            if (local_time_counter_ns >= `NS_PER_SEC - `CLK_PERIOD_NS) begin
                local_time_counter_ns  <= local_time_counter_ns
                    + `CLK_PERIOD_NS - `NS_PER_SEC;
                local_time_counter_sec <= local_time_counter_sec + 48'h1;
            end else begin
                local_time_counter_ns <= local_time_counter_ns
                    + `CLK_PERIOD_NS;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            capture_prev <= 1'b0;
            capture_sec  <= 48'h0;
            capture_ns   <= 30'h0;
        end else begin
            capture_prev <= gpio_capture_in;
            if (sync_global_enable && (gpio_capture_in != capture_prev)) begin
                capture_sec <= local_time_counter_sec;
                capture_ns  <= local_time_counter_ns;
            end
        end
    end

    // Disable waits for every port to finish its current frame.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state               <= time_event_pkg::stamp_idle;
            sync_global_enable  <= 1'b0;
            sync_global_disable <= 1'b0;
        end else begin
            unique case (state)
                time_event_pkg::stamp_idle: begin
                    if (enable_set) begin
                        sync_global_enable <= 1'b1;
                        state              <= time_event_pkg::stamp_busy;
                    end
                end
                time_event_pkg::stamp_busy: begin
                    if (disable_set) begin
                        sync_global_disable <= 1'b1;
                        state               <= time_event_pkg::stamp_drain;
                    end
                end
                time_event_pkg::stamp_drain: begin
                    if (port_frame_busy == 4'h0) begin
                        sync_global_enable  <= 1'b0;
                        sync_global_disable <= 1'b0;
                        state               <= time_event_pkg::stamp_idle;
                    end
                end
            endcase
        end
    end

    // New frames are not started once disable is pending.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            port_process_enable <= 4'h0;
            stamp_bypass        <= 1'b1;
        end else begin
            port_process_enable <= port_stamp_unit_enable
                & {4{sync_global_enable & ~sync_global_disable
                     & ~disable_set}};
            stamp_bypass        <= ~sync_global_enable;
        end
    end
endmodule

// ### testbench/ptp_time_event_compare_monitor.sv
// Purpose: Port-level checker for the time event comparator.
// Assumes: One clock domain; every watched port is synchronous to mclk.
// Notes: Bound to every instance of the top module.
`timescale 1ns/1ps
module ptp_time_event_compare_monitor (
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        counter_load,
    input wire logic [3:0]  port_frame_busy,
    input wire logic [1:0]  irq_clear,
    input wire logic [1:0]  gpio_irq_clear,
    input wire logic [47:0] local_time_counter_sec,
    input wire logic [29:0] local_time_counter_ns,
    input wire logic        sync_global_enable,
    input wire logic        sync_global_disable,
    input wire logic [3:0]  port_process_enable,
    input wire logic        stamp_bypass,
    input wire logic        event_irq_chan_a,
    input wire logic        event_irq_chan_b,
    input wire logic [47:0] capture_sec,
    input wire logic [1:0]  event_pin
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    // Each $past antecedent also checks reset, so a short reset is safe.
    property p_tick;
        !$past(sys_rst) && $past(sync_global_enable) && !$past(counter_load)
        && $past(local_time_counter_ns) < 30'h3B9AC9F6 |->
        local_time_counter_ns == $past(local_time_counter_ns) + 30'h0000000A;
    endproperty
    a_tick: assert property (p_tick) else $error("counter step wrong");
    property p_wrap;
        !$past(sys_rst) && $past(sync_global_enable) && !$past(counter_load)
        && $past(local_time_counter_ns) == 30'h3B9AC9F6 |->
        local_time_counter_ns == 30'h0 &&
        local_time_counter_sec == $past(local_time_counter_sec) + 48'h1;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter wrap wrong");
    property p_halt;
        !$past(sys_rst) && !sync_global_enable && !$past(sync_global_enable)
        && !$past(counter_load) |-> $stable(local_time_counter_ns);
    endproperty
    a_halt: assert property (p_halt) else $error("counter moved");
    // A run counter stands in for a long repetition of the pin level.
    logic [4:0] pin_run;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pin_run <= 5'h00;
        end else if (!event_pin[0]) begin
            pin_run <= 5'h00;
        end else if (pin_run != 5'h1F) begin
            pin_run <= pin_run + 5'h01;
        end
    end
    property p_pulse;
        $fell(event_pin[0]) |-> pin_run == 5'h0A;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pin width");
    property p_irq_set;
        $rose(event_pin[1]) |=> event_irq_chan_b;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("no flag");
    property p_irq_clr;
        $fell(event_irq_chan_a) && !$past(sys_rst) && !$past(sys_rst, 2)
        |-> $past(irq_clear[0], 2) || $past(gpio_irq_clear[0], 2);
    endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("flag lost");
    property p_port;
        port_process_enable != 4'h0 |->
        sync_global_enable && !sync_global_disable;
    endproperty
    a_port: assert property (p_port) else $error("port gating");
    property p_hold;
        sync_global_disable && port_frame_busy != 4'h0 |=> sync_global_enable;
    endproperty
    a_hold: assert property (p_hold) else $error("early stop");
    property p_drain;
        sync_global_disable && port_frame_busy == 4'h0 |->
        ##[1:2] !sync_global_enable && !sync_global_disable;
    endproperty
    a_drain: assert property (p_drain) else $error("no drain");
    property p_bypass;
        !sync_global_enable [*2] |-> stamp_bypass;
    endproperty
    a_bypass: assert property (p_bypass) else $error("no bypass");
    property p_capture;
        !$past(sys_rst) && !sync_global_enable && !$past(sync_global_enable)
        |-> $stable(capture_sec);
    endproperty
    a_capture: assert property (p_capture) else $error("capture moved");
endmodule
bind ptp_time_event_compare ptp_time_event_compare_monitor mon_u (
    .mclk, .sys_rst, .counter_load, .port_frame_busy, .irq_clear,
    .gpio_irq_clear, .local_time_counter_sec, .local_time_counter_ns,
    .sync_global_enable, .sync_global_disable, .port_process_enable,
    .stamp_bypass, .event_irq_chan_a, .event_irq_chan_b, .capture_sec,
    .event_pin
);

// ### testbench/ptp_time_event_compare_tb.sv
// Purpose: Self-checking bench for the time event comparator.
// Assumes: Strobes last one cycle; counter steps 10 ns per cycle.
// Notes: Quarter writes leave a one-cycle gap between strobes.
`timescale 1ns/1ps
module ptp_time_event_compare_tb;
    logic        mclk = 1'b0, sys_rst = 1'b1, counter_load = 1'b0;
    logic [47:0] counter_load_sec = 48'h0;
    logic [29:0] counter_load_ns = 30'h0;
    logic [1:0]  target_wr = 2'h0, rearm_wr = 2'h0, quarter_sel = 2'h0;
    logic [15:0] quarter_data = 16'h0;
    logic        target_readback_cmd = 1'b0, enable_set = 1'b0;
    logic        disable_set = 1'b0, gpio_capture_in = 1'b0;
    logic [1:0]  rearm_reload = 2'h2, irq_clear = 2'h0;
    logic [1:0]  gpio_irq_clear = 2'h0, event_pin, gpio_event_out;
    logic [3:0]  port_stamp_unit_enable = 4'hA, port_frame_busy = 4'h0;
    logic [47:0] local_time_counter_sec, capture_sec;
    logic [29:0] local_time_counter_ns, capture_ns, actual_ns_a, actual_ns_b;
    logic        sync_global_enable, sync_global_disable, stamp_bypass;
    logic [3:0]  port_process_enable;
    logic        event_irq_chan_a, event_irq_chan_b;
    logic [31:0] event_target_seconds_a, event_target_seconds_b;
    logic [29:0] event_target_nanoseconds_a, event_target_nanoseconds_b;
    int          n_fail = 0, tests_run = 0;
    always #5 mclk = ~mclk;
    ptp_time_event_compare dut_u (
        .mclk, .sys_rst, .counter_load, .counter_load_sec, .counter_load_ns,
        .target_wr, .rearm_wr, .quarter_sel, .quarter_data,
        .target_readback_cmd, .rearm_reload, .enable_set, .disable_set,
        .port_stamp_unit_enable, .port_frame_busy, .irq_clear,
        .gpio_irq_clear, .gpio_capture_in, .local_time_counter_sec,
        .local_time_counter_ns, .sync_global_enable, .sync_global_disable,
        .port_process_enable, .stamp_bypass, .event_irq_chan_a,
        .event_irq_chan_b, .event_target_seconds_a,
        .event_target_nanoseconds_a, .event_target_seconds_b,
        .event_target_nanoseconds_b, .actual_ns_a, .actual_ns_b,
        .capture_sec, .capture_ns, .event_pin, .gpio_event_out
    );
    task automatic wrap_up;
        if (n_fail == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // One-cycle strobe on one of the pulse inputs, picked by k.
    task automatic strobe(input int k);
        @(posedge mclk);
        case (k)
            0: counter_load <= 1'b1;
            1: target_readback_cmd <= 1'b1;
            2: enable_set <= 1'b1;
            3: disable_set <= 1'b1;
            4: irq_clear <= 2'h1;
            default: gpio_irq_clear <= 2'h2;
        endcase
        @(posedge mclk);
        {counter_load, target_readback_cmd, enable_set, disable_set} <= 4'h0;
        {irq_clear, gpio_irq_clear} <= 4'h0;
    endtask
    task automatic wq(input bit rm, input int ch, input int q,
                      input logic [31:0] s, input logic [29:0] ns);
        @(posedge mclk);
        quarter_sel <= q[1:0];
        quarter_data <= q == 0 ? ns[15:0] : q == 1 ? {2'h0, ns[29:16]} :
                        q == 2 ? s[15:0] : s[31:16];
        if (rm) rearm_wr[ch] <= 1'b1;
        else target_wr[ch] <= 1'b1;
        @(posedge mclk);
        target_wr <= 2'h0;
        rearm_wr <= 2'h0;
    endtask
    // Order holds four quarter numbers, first one in the low bits.
    task automatic wset(input bit rm, input int ch, input logic [31:0] s,
                        input logic [29:0] ns, input logic [7:0] ord);
        for (int i = 0; i < 4; i++) wq(rm, ch, int'(ord[2*i+:2]), s, ns);
    endtask
    task automatic rb(input logic [31:0] as, input logic [29:0] an,
                      input logic [31:0] bs, input logic [29:0] bn);
        tick(2);
        strobe(1);
        #1;
        chk(event_target_seconds_a, as);
        chk(event_target_nanoseconds_a, an);
        chk(event_target_seconds_b, bs);
        chk(event_target_nanoseconds_b, bn);
    endtask
    task automatic wirq(input int ch);
        int i;
        for (i = 0; i < 300; i++) begin
            @(posedge mclk);
            if ((ch == 0 ? event_irq_chan_a : event_irq_chan_b) === 1'b1) break;
        end
        #1;
        if (i == 300) begin
            n_fail++;
            wrap_up();
        end
    endtask
    initial begin
        int          i;
        logic [29:0] sv;
        tick(5);
        sys_rst <= 1'b0;
        tick(1);
        #1;
        chk(stamp_bypass, 64'h1);
        chk(sync_global_enable, 64'h0);
        chk(port_process_enable, 64'h0);
        counter_load_sec <= 48'h000100000005;
        counter_load_ns <= 30'h3B9AC99C;
        strobe(0);
        #1;
        chk(local_time_counter_sec, 64'h000100000005);
        chk(local_time_counter_ns, 64'h3B9AC99C);
        for (i = 0; i < 3; i++) wq(0, 1, i, 32'h5, 30'h3B9AC9F6);
        rb(32'h0, 30'h0, 32'h0, 30'h0);
        wq(0, 1, 3, 32'h5, 30'h3B9AC9F6);
        wset(0, 0, 32'h5, 30'h3B9AC9CE, 8'h87);
        rb(32'h5, 30'h3B9AC9CE, 32'h5, 30'h3B9AC9F6);
        wset(1, 0, 32'h1, 30'h64, 8'hE4);
        wset(1, 1, 32'h9, 30'h0, 8'h1B);
        strobe(2);
        #1;
        chk(sync_global_enable, 64'h1);
        wirq(0);
        chk(actual_ns_a, 64'h3B9AC9CE);
        chk(event_pin[0], 64'h1);
        chk(gpio_event_out, 64'h1);
        chk(port_process_enable, 64'hA);
        chk(stamp_bypass, 64'h0);
        wirq(1);
        chk(actual_ns_b, 64'h3B9AC9F6);
        rb(32'h7, 30'h32, 32'h9, 30'h0);
        gpio_capture_in <= 1'b1;
        tick(3);
        #1;
        chk(capture_sec, 64'h000100000006);
        chk(capture_ns, 64'h3C);
        strobe(4);
        tick(1);
        #1;
        chk(event_irq_chan_a, 64'h0);
        strobe(5);
        tick(1);
        #1;
        chk(event_irq_chan_b, 64'h0);
        counter_load_sec <= 48'h000100000007;
        counter_load_ns <= 30'h64;
        strobe(0);
        wirq(0);
        chk(actual_ns_a, 64'h64);
        tick(20);
        #1;
        chk(event_irq_chan_a, 64'h1);
        port_frame_busy <= 4'h2;
        strobe(3);
        #1;
        chk(sync_global_disable, 64'h1);
        chk(port_process_enable, 64'h0);
        tick(5);
        #1;
        chk(sync_global_enable, 64'h1);
        port_frame_busy <= 4'h0;
        for (i = 0; i < 10 && sync_global_enable === 1'b1; i++) tick(1);
        if (i == 10) begin
            n_fail++;
            wrap_up();
        end
        tick(2);
        #1;
        chk(sync_global_disable, 64'h0);
        chk(stamp_bypass, 64'h1);
        sv = local_time_counter_ns;
        gpio_capture_in <= 1'b0;
        tick(5);
        #1;
        chk(local_time_counter_ns, sv);
        chk(capture_sec, 64'h000100000006);
        strobe(4);
        counter_load_sec <= 48'h000100000008;
        counter_load_ns <= 30'h3B9AC618;
        strobe(0);
        tick(10);
        #1;
        chk(event_irq_chan_a, 64'h0);
        chk(local_time_counter_sec, 64'h000100000008);
        rb(32'h8, 30'h96, 32'h9, 30'h0);
        wrap_up();
    end
endmodule
